//--- rtl/tmw_cmd_exec.sv
// Command executor for status read, write, quad write, lock, inquiry, broadcast.
// Assumes the line decoder supplies a one-cycle command strobe with checked fields.
`default_nettype none
module tmw_cmd_exec
   import tmw_pkg::*;
#(
   parameter logic [TMW_ID_W-1:0] UID_VALUE = 64'h0123456789ABCDEF, // Arbitrary value
   parameter int                  PROG_CYC  = TMW_PROG_CYC
) (
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_in,
   input  wire logic                 cmd_valid_in,
   output logic                      cmd_ready_out,
   input  wire logic                 cmd_crc_ok_in,
   input  wire tmw_cmd_e             cmd_code_in,
   input  wire logic [TMW_ID_W-1:0]  received_tag_number_in,
   input  wire logic [7:0]           cmd_addr_in,
   input  wire logic [7:0]           cmd_mask_in,
   input  wire logic [31:0]          cmd_data_in,
   input  wire logic                 ident_in,
   output logic                      rsp_valid_out,
   output tmw_rsp_e                  rsp_code_out,
   output logic [7:0]                rsp_byte_out,
   output logic                      nv_we_out,
   output logic [7:0]                nv_addr_out,
   output logic [3:0]                nv_be_out,
   output logic [31:0]               nv_data_out,
   input  wire logic                 nv_ok_in,
   output logic                      transfer_state_sticky_bit_out,
   output logic                      write_ok_out
);
   default clocking chk_cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   // ***********************************************************
   // Decode
   // ***********************************************************
   tmw_tag_e    state_q;
   logic [3:0]  locked4;
   logic        lockable;
   logic        busy;
   logic        done;
   logic        id_match;
   logic        take;
   logic        set_lock;
   logic        mark;
   logic        start_prog;
   logic        pend_lock_q;
   logic        pend_wflag_q;
   logic [7:0]  pend_addr_q;
   logic        addr_valid;
   logic [3:0]  sel;

   assign id_match      = (received_tag_number_in == UID_VALUE);
   assign cmd_ready_out = !busy;
   assign take          = cmd_valid_in && cmd_crc_ok_in && !busy;
   assign addr_valid    = (cmd_addr_in <= TMW_LAST_ADDR);
   assign sel           = cmd_mask_in[TMW_MASK_FIRST -: 4];

   tmw_lock_store u_locks (
      .clk_sys_in   (clk_sys_in),
      .rst_in       (rst_in),
      .rd_addr_in   (cmd_addr_in),
      .locked4_out  (locked4),
      .lockable_out (lockable),
      .set_lock_in  (set_lock),
      .lock_addr_in (pend_addr_q),
      .mark_in      (mark),
      .mark_addr_in (cmd_addr_in)
   );

   tmw_prog_timer #(.CYCLES(PROG_CYC)) u_timer (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .start_in   (start_prog),
      .busy_out   (busy),
      .done_out   (done)
   );

   // ***********************************************************
   // Command evaluation
   // ***********************************************************
   logic     rsp_d;
   tmw_rsp_e code_d;
   logic     xfer_d;
   logic     wflag_d;
   logic     do_prog;
   logic     do_lock;

   always_comb begin
      rsp_d      = 1'b0;
      code_d     = TMW_RSP_BYTE;
      xfer_d     = 1'b0;
      wflag_d    = 1'b0;
      do_prog    = 1'b0;
      do_lock    = 1'b0;
      mark       = 1'b0;
      if (take) begin
         unique case (cmd_code_in)
            TMW_CMD_READ_PORT: if (id_match) begin
               rsp_d  = 1'b1;
               xfer_d = 1'b1;
            end
            TMW_CMD_WRITE: if (id_match) begin
               xfer_d = 1'b1;
               rsp_d  = 1'b1;
               mark   = 1'b1;
               if (locked4[3]) begin
                  code_d  = TMW_RSP_ERR;
                  wflag_d = 1'b1;
               end else begin
                  code_d  = TMW_RSP_ACK;
                  do_prog = 1'b1;
               end
            end
            TMW_CMD_QUAD: if (id_match) begin
               xfer_d = 1'b1;
               rsp_d  = 1'b1;
               if (|locked4) begin
                  code_d  = TMW_RSP_ERR;
                  wflag_d = 1'b1;
               end else begin
                  code_d  = TMW_RSP_ACK;
                  do_prog = 1'b1;
               end
            end
            TMW_CMD_LOCK: if (id_match && state_q == TMW_ST_XFER) begin
               rsp_d = 1'b1;
               if (addr_valid && lockable) begin
                  code_d  = TMW_RSP_ACK;
                  do_lock = 1'b1;
               end else begin
                  code_d  = TMW_RSP_ACK_NOK;
                  wflag_d = 1'b1;
               end
            end
            TMW_CMD_QUERY: if (id_match) begin
               xfer_d = 1'b1;
               rsp_d  = 1'b1;
               mark   = 1'b1;
               if (locked4[3]) begin
                  code_d = write_ok_out ? TMW_RSP_ERR_OK : TMW_RSP_ERR_NOK;
               end else begin
                  code_d = write_ok_out ? TMW_RSP_ACK_OK : TMW_RSP_ACK_NOK;
               end
            end
            TMW_CMD_BCAST: if (state_q != TMW_ST_READY || ident_in) begin
               if (locked4[3]) begin
                  wflag_d = 1'b1;
               end else begin
                  do_prog = 1'b1;
               end
            end
            TMW_CMD_INIT: ;
            default: ;
         endcase
      end
   end

   assign start_prog = do_prog || do_lock;

   // ***********************************************************
   // Tag state and transfer bit
   // ***********************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_q <= TMW_ST_READY;
      end else if (take && cmd_code_in == TMW_CMD_INIT) begin
         state_q <= TMW_ST_READY;
      end else if (xfer_d) begin
         state_q <= TMW_ST_XFER;
      end else if (ident_in && state_q == TMW_ST_READY) begin
         state_q <= TMW_ST_IDENT;
      end
   end
   assign transfer_state_sticky_bit_out = (state_q == TMW_ST_XFER);

   // ***********************************************************
   // Response output
   // ***********************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rsp_valid_out <= 1'b0;
         rsp_code_out  <= TMW_RSP_BYTE;
         rsp_byte_out  <= '0;
      end else begin
         // Broadcast and initialize never reach rsp_d
         rsp_valid_out <= rsp_d;
         rsp_code_out  <= code_d;
         if (cmd_code_in == TMW_CMD_READ_PORT && cmd_addr_in == TMW_PORT_STATUS) begin
            rsp_byte_out <= TMW_RSVD_READ;
            rsp_byte_out[TMW_BIT_XFER] <= xfer_d || transfer_state_sticky_bit_out;
            rsp_byte_out[TMW_BIT_WOK]  <= write_ok_out;
         end else begin
            rsp_byte_out <= TMW_RSVD_READ;
         end
      end
   end

   // ***********************************************************
   // Programming and write flag
   // ***********************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         nv_we_out   <= 1'b0;
         nv_addr_out <= '0;
         nv_be_out   <= '0;
         nv_data_out <= '0;
      end else begin
         // Strobe is registered with the response: acknowledge and strobe appear in the same cycle
         nv_we_out <= do_prog;
         if (do_prog) begin
            nv_addr_out <= cmd_addr_in;
            nv_data_out <= cmd_data_in;
            nv_be_out   <= (cmd_code_in == TMW_CMD_QUAD) ? sel : 4'b1000;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pend_lock_q  <= 1'b0;
         pend_wflag_q <= 1'b0;
         pend_addr_q  <= '0;
      end else if (start_prog) begin
         pend_lock_q  <= do_lock;
         pend_wflag_q <= nv_ok_in;
         pend_addr_q  <= cmd_addr_in;
      end else if (done) begin
         pend_lock_q <= 1'b0;
      end
   end
   assign set_lock = done && pend_lock_q && pend_wflag_q;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         write_ok_out <= 1'b0;
      end else if (done) begin
         write_ok_out <= pend_wflag_q;
      end else if (wflag_d) begin
         write_ok_out <= 1'b0;
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   chk_mismatch_silent: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && !id_match && cmd_code_in inside {TMW_CMD_READ_PORT, TMW_CMD_WRITE,
      TMW_CMD_QUAD, TMW_CMD_LOCK, TMW_CMD_QUERY} |=> !rsp_valid_out)
      else $error("reply sent on ID mismatch");
   chk_bcast_silent: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && cmd_code_in == TMW_CMD_BCAST |=> !rsp_valid_out)
      else $error("reply sent to broadcast write");
   chk_locked_error: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && id_match && cmd_code_in == TMW_CMD_WRITE && locked4[3]
      |=> rsp_valid_out && rsp_code_out == TMW_RSP_ERR && !nv_we_out)
      else $error("locked write not refused");
   chk_ack_then_prog: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && id_match && cmd_code_in == TMW_CMD_WRITE && !locked4[3]
      |=> rsp_valid_out && rsp_code_out == TMW_RSP_ACK && nv_we_out)
      else $error("unlocked write not acknowledged and programmed");
   chk_quad_mask: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && id_match && cmd_code_in == TMW_CMD_QUAD && !(|locked4)
      |=> nv_we_out && nv_be_out == $past(cmd_mask_in[7:4]))
      else $error("quad write mask not honoured");
   chk_quad_locked: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && id_match && cmd_code_in == TMW_CMD_QUAD && (|locked4)
      |=> !nv_we_out && rsp_code_out == TMW_RSP_ERR)
      else $error("locked quad write programmed");
   chk_lock_nok: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && id_match && cmd_code_in == TMW_CMD_LOCK && state_q == TMW_ST_XFER && !lockable
      |=> rsp_code_out == TMW_RSP_ACK_NOK ##1 !busy)
      else $error("unlockable byte not refused");
   chk_init_clears: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      take && cmd_code_in == TMW_CMD_INIT |=> !transfer_state_sticky_bit_out && !rsp_valid_out)
      else $error("initialize did not clear transfer bit");
   chk_busy_refuse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      start_prog |=> !cmd_ready_out [*2])
      else $error("command accepted while programming");
   chk_bad_crc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cmd_valid_in && !cmd_crc_ok_in && !busy |=> !rsp_valid_out && $stable(state_q))
      else $error("failed checksum command acted on");

   chk_read_enter: assert property (
      take && id_match && cmd_code_in == TMW_CMD_READ_PORT
      |=> rsp_valid_out && rsp_code_out == TMW_RSP_BYTE
      && transfer_state_sticky_bit_out)
      else $error("status read did not enter transfer");

   chk_port_rsvd: assert property (
      rsp_valid_out && rsp_code_out == TMW_RSP_BYTE
      |-> rsp_byte_out[7:2] == 6'h00)
      else $error("reserved status bits not zero");

   chk_port_high: assert property (
      take && cmd_code_in == TMW_CMD_READ_PORT
      && cmd_addr_in != TMW_PORT_STATUS
      |=> rsp_byte_out == TMW_RSVD_READ)
      else $error("reserved port not zero");

   chk_bcast_prog: assert property (
      take && cmd_code_in == TMW_CMD_BCAST && !locked4[3]
      && (state_q != TMW_ST_READY || ident_in)
      |=> nv_we_out && nv_be_out == 4'b1000)
      else $error("broadcast write not programmed");

   chk_bcast_ready: assert property (
      take && cmd_code_in == TMW_CMD_BCAST
      && state_q == TMW_ST_READY && !ident_in
      |=> !nv_we_out && cmd_ready_out)
      else $error("broadcast acted on in ready state");

   chk_lock_gate: assert property (
      take && cmd_code_in == TMW_CMD_LOCK && state_q != TMW_ST_XFER
      |=> !rsp_valid_out && cmd_ready_out)
      else $error("lock honoured outside transfer state");

   chk_lock_prog: assert property (
      take && id_match && cmd_code_in == TMW_CMD_LOCK
      && state_q == TMW_ST_XFER && lockable
      |=> rsp_valid_out && rsp_code_out == TMW_RSP_ACK && !cmd_ready_out)
      else $error("lockable byte not acknowledged and programmed");

   chk_wflag_late: assert property (
      $rose(write_ok_out) |-> $past(done))
      else $error("write flag set before programming end");

   chk_query_ok: assert property (
      take && id_match && cmd_code_in == TMW_CMD_QUERY
      && !locked4[3] && write_ok_out
      |=> rsp_valid_out && rsp_code_out == TMW_RSP_ACK_OK)
      else $error("inquiry answer code wrong");

   chk_crc_quiet: assert property (
      cmd_valid_in && !cmd_crc_ok_in && !busy
      |=> $stable(write_ok_out) && !nv_we_out)
      else $error("failed checksum changed flag or memory");

   chk_wflag_clear: assert property (
      take && id_match && cmd_code_in == TMW_CMD_WRITE && locked4[3]
      |=> !write_ok_out)
      else $error("refused write left flag set");
endmodule
`default_nettype wire

//--- rtl/tmw_pkg.sv
// Constants and types for the tag write and lock command executor.
// Assumes a decoded, checksum-qualified command arrives from a line decoder.
// Overview of operation
// - Status-port read on ID match: enter transfer, return byte
// - Port 0 bit0 transfer bit, bit1 write flag
// - Mismatch, failed checksum or lock outside transfer state: no reply at all
// - Single write, match: transfer state, locked gives error
// - Single write unlocked: acknowledge, then program byte
// - Write-type commands set or clear write flag
// - Single write marks addressed byte lockable
// - Quad write, any byte locked: error, nothing programmed
// - Quad write acknowledges, programs masked bytes B7..B4
// - Quad write marks no byte lockable
// - Lock in transfer state, valid, lockable: ack, program
// - Lock out of range or unlockable: negative acknowledge
// - Protection inquiry answers ack/err by lock and flag
// - Protection inquiry marks queried byte lockable
// - Broadcast write needs no ID, identified or transfer
// - Broadcast write never answers
// - Initialize returns to ready, clears transfer bit, silent
`default_nettype none
package tmw_pkg;
   typedef enum logic [2:0] {
      TMW_CMD_READ_PORT,
      TMW_CMD_WRITE,
      TMW_CMD_QUAD,
      TMW_CMD_LOCK,
      TMW_CMD_QUERY,
      TMW_CMD_BCAST,
      TMW_CMD_INIT
   } tmw_cmd_e;
   typedef enum logic [2:0] {
      TMW_RSP_BYTE,
      TMW_RSP_ACK,
      TMW_RSP_ERR,
      TMW_RSP_ACK_OK,
      TMW_RSP_ACK_NOK,
      TMW_RSP_ERR_OK,
      TMW_RSP_ERR_NOK
   } tmw_rsp_e;
   typedef enum logic [1:0] {
      TMW_ST_READY,
      TMW_ST_IDENT,
      TMW_ST_XFER
   } tmw_tag_e;
   localparam int          TMW_ID_W        = 64;
   localparam int          TMW_ADDR_W      = 8;
   localparam int          TMW_MEM_BYTES   = 256;
   localparam logic [7:0]  TMW_LAST_ADDR   = 8'hFF;
   localparam logic [7:0]  TMW_PORT_STATUS = 8'h00;
   localparam int          TMW_BIT_XFER    = 0;
   localparam int          TMW_BIT_WOK     = 1;
   localparam logic [7:0]  TMW_RSVD_READ   = 8'h00;
   localparam int          TMW_MASK_FIRST  = 7;
   localparam real         TMW_PROG_MS     = 13.3;
   localparam real         TMW_CLK_MHZ     = 20.0;
   localparam int          TMW_PROG_CYC    = int'(TMW_PROG_MS * TMW_CLK_MHZ * 1000.0);
endpackage
`default_nettype wire

//--- rtl/tmw_lock_store.sv
// Per-byte lock bits and lockable marks.
// Assumes the executor drives at most one update of each kind per cycle.
`default_nettype none
module tmw_lock_store
   import tmw_pkg::*;
#(
   parameter int DEPTH = TMW_MEM_BYTES
) (
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   input  wire logic [7:0]       rd_addr_in,
   output logic      [3:0]       locked4_out,
   output logic                  lockable_out,
   input  wire logic             set_lock_in,
   input  wire logic [7:0]       lock_addr_in,
   input  wire logic             mark_in,
   input  wire logic [7:0]       mark_addr_in
);
   initial if (DEPTH != 256) $error("lock store depth must be 256");
   logic [DEPTH-1:0] lock_q;
   logic [DEPTH-1:0] lockable_q;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         lock_q <= '0;
      end else if (set_lock_in) begin
         lock_q[lock_addr_in] <= 1'b1;
      end
   end

   // Marks live in volatile state; a new mark replaces nothing else
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         lockable_q <= '0;
      end else if (mark_in) begin
         lockable_q[mark_addr_in] <= 1'b1;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         locked4_out[3-i] = lock_q[8'(rd_addr_in + 8'(i))];
      end
      lockable_out = lockable_q[rd_addr_in];
   end
endmodule
`default_nettype wire

//--- rtl/tmw_prog_timer.sv
// Nonvolatile programming timer; busy for the programming time.
// Assumes start is only pulsed while idle.
`default_nettype none
module tmw_prog_timer
   import tmw_pkg::*;
#(
   parameter int CYCLES = TMW_PROG_CYC
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic start_in,
   output logic      busy_out,
   output logic      done_out
);
   initial if (CYCLES < 1) $error("programming time must be at least one cycle");
   logic [31:0] cnt_q;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cnt_q    <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= (cnt_q == 32'd1);
         if (start_in) begin
            cnt_q <= 32'(CYCLES);
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 32'd1;
         end
      end
   end
   assign busy_out = (cnt_q != '0) || done_out;
endmodule
`default_nettype wire

//--- dv/tmw_rdr_model.sv
// Interrogator model: sends one decoded command frame and captures the tag's answer.
// Assumes tb_top provides the hang task for a wait that runs out.
`default_nettype none
module tmw_rdr_model
   import tmw_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        cmd_ready_in,
   input  wire logic        rsp_valid_in,
   input  wire tmw_rsp_e    rsp_code_in,
   input  wire logic [7:0]  rsp_byte_in,
   input  wire logic        nv_we_in,
   input  wire logic [7:0]  nv_addr_in,
   input  wire logic [3:0]  nv_be_in,
   input  wire logic [31:0] nv_data_in,
   output logic             cmd_valid_out,
   output logic             cmd_crc_ok_out,
   output tmw_cmd_e         cmd_code_out,
   output logic [63:0]      tag_number_out,
   output logic [7:0]       addr_out,
   output logic [7:0]       mask_out,
   output logic [31:0]      data_out,
   output logic             nv_ok_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        seen_rsp;
   tmw_rsp_e    seen_code;
   logic [7:0]  seen_byte;
   logic        seen_we;
   logic [7:0]  seen_addr;
   logic [3:0]  seen_be;
   logic [31:0] seen_data;
   logic        seen_busy;

   initial begin
      cmd_valid_out  = 1'b0;
      cmd_crc_ok_out = 1'b0;
      cmd_code_out   = TMW_CMD_INIT;
      tag_number_out = 64'h0;
      addr_out       = 8'h00;
      mask_out       = 8'h00;
      data_out       = 32'h0;
      nv_ok_out      = 1'b0;
   end

   // ************************************************************
   // Frame transfer
   // ************************************************************
   // Fields other than the command code are inverted once released so a stale value can never match
   task automatic issue(input tmw_cmd_e c, input logic [63:0] id, input logic [7:0] a,
                        input logic [7:0] m, input logic [31:0] d, input logic crc,
                        input logic ok);
      int n;
      @(posedge clk_sys_in);
      cmd_valid_out  <= 1'b1;
      cmd_crc_ok_out <= crc;
      cmd_code_out   <= c;
      tag_number_out <= id;
      addr_out       <= (c == TMW_CMD_QUAD) ? {a[7:2], 2'b00} : a;
      mask_out       <= m;
      data_out       <= d;
      nv_ok_out      <= ok;
      @(posedge clk_sys_in);
      cmd_valid_out  <= 1'b0;
      cmd_crc_ok_out <= ~crc;
      tag_number_out <= ~id;
      addr_out       <= ~a;
      mask_out       <= ~m;
      data_out       <= ~d;
      nv_ok_out      <= ~ok;
      #1;
      seen_rsp  = rsp_valid_in;
      seen_code = rsp_code_in;
      seen_byte = rsp_byte_in;
      seen_we   = nv_we_in;
      seen_addr = nv_addr_in;
      seen_be   = nv_be_in;
      seen_data = nv_data_in;
      seen_busy = ~cmd_ready_in;
      // Broadcast frames leave no reply slot; the same wait follows them
      n = 0;
      while (cmd_ready_in !== 1'b1 && n < 100) begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end
      if (n >= 100) tb_top.hang();
   endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the tag command executor.
// Assumes a shortened programming time parameter for simulation.
`default_nettype none
module tb_top
   import tmw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          PROG    = 5;
   localparam logic [63:0] TAG_UID = 64'h5A5A0F0FC3C31234; // Arbitrary value
   localparam logic [63:0] OTHER   = 64'h5A5A0F0FC3C31235;
   logic        clk_sys_in;
   logic        rst_in;
   logic        ident;
   logic        cmd_valid, crc_ok, ready, rsp_valid, nv_we, nv_ok, xfer, wok;
   tmw_cmd_e    code;
   tmw_rsp_e    rcode;
   logic [63:0] id;
   logic [7:0]  addr, mask, rbyte, nv_addr;
   logic [3:0]  nv_be;
   logic [31:0] data, nv_data;
   int          mismatches;
   int          samples_checked;

   initial clk_sys_in = 1'b0;
   always #25 clk_sys_in = ~clk_sys_in;

   tmw_cmd_exec #(.UID_VALUE(TAG_UID), .PROG_CYC(PROG)) u_dut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
      .cmd_ready_out(ready), .cmd_crc_ok_in(crc_ok), .cmd_code_in(code),
      .received_tag_number_in(id), .cmd_addr_in(addr), .cmd_mask_in(mask),
      .cmd_data_in(data), .ident_in(ident), .rsp_valid_out(rsp_valid),
      .rsp_code_out(rcode), .rsp_byte_out(rbyte), .nv_we_out(nv_we),
      .nv_addr_out(nv_addr), .nv_be_out(nv_be), .nv_data_out(nv_data), .nv_ok_in(nv_ok),
      .transfer_state_sticky_bit_out(xfer), .write_ok_out(wok));

   tmw_rdr_model u_rdr (
      .clk_sys_in(clk_sys_in), .cmd_ready_in(ready), .rsp_valid_in(rsp_valid),
      .rsp_code_in(rcode), .rsp_byte_in(rbyte), .nv_we_in(nv_we), .nv_addr_in(nv_addr),
      .nv_be_in(nv_be), .nv_data_in(nv_data), .cmd_valid_out(cmd_valid),
      .cmd_crc_ok_out(crc_ok), .cmd_code_out(code), .tag_number_out(id),
      .addr_out(addr), .mask_out(mask), .data_out(data), .nv_ok_out(nv_ok));

   // ************************************************************
   // Shared helpers
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic rsp_is(input logic v, input tmw_rsp_e c, input logic we);
      check("rsp_valid", 32'(u_rdr.seen_rsp), 32'(v));
      if (v) check("rsp_code", 32'(u_rdr.seen_code), 32'(c));
      check("nv_we", 32'(u_rdr.seen_we), 32'(we));
   endtask

   task automatic go(input tmw_cmd_e c, input logic [63:0] i, input logic [7:0] a,
                     input logic [7:0] m, input logic [31:0] d, input logic ok);
      u_rdr.issue(c, i, a, m, d, 1'b1, ok);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic hang();
      mismatches++;
      $display("Error cmd_ready expected 1 seen 0");
      results();
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_read();
      logic [7:0] e;
      u_rdr.issue(TMW_CMD_READ_PORT, TAG_UID, TMW_PORT_STATUS, 8'h00, 32'h0, 1'b0, 1'b1);
      rsp_is(1'b0, TMW_RSP_BYTE, 1'b0);
      check("xfer", 32'(xfer), 32'h0);
      go(TMW_CMD_READ_PORT, OTHER, TMW_PORT_STATUS, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b0, TMW_RSP_BYTE, 1'b0);
      go(TMW_CMD_READ_PORT, TAG_UID, TMW_PORT_STATUS, 8'h00, 32'h0, 1'b1);
      e = 8'h00;
      e[TMW_BIT_XFER] = 1'b1;
      rsp_is(1'b1, TMW_RSP_BYTE, 1'b0);
      check("status_flags_port", 32'(u_rdr.seen_byte), 32'(e));
      go(TMW_CMD_READ_PORT, TAG_UID, 8'h01, 8'h00, 32'h0, 1'b1);
      check("reserved_port_one", 32'(u_rdr.seen_byte), 32'(TMW_RSVD_READ));
      $display("test read_port done");
   endtask

   task automatic t_write();
      go(TMW_CMD_WRITE, TAG_UID, 8'h10, 8'h00, 32'h5A000000, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK, 1'b1);
      check("nv_addr", 32'(u_rdr.seen_addr), 32'h10);
      check("nv_be", 32'(u_rdr.seen_be), 32'h8);
      check("nv_data", 32'(u_rdr.seen_data[31:24]), 32'h5A);
      check("busy", 32'(u_rdr.seen_busy), 32'h1);
      check("write_ok", 32'(wok), 32'h1);
      go(TMW_CMD_WRITE, TAG_UID, 8'h10, 8'h00, 32'hA5000000, 1'b0);
      rsp_is(1'b1, TMW_RSP_ACK, 1'b1);
      check("write_ok", 32'(wok), 32'h0);
      go(TMW_CMD_LOCK, TAG_UID, 8'h10, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK, 1'b0);
      check("write_ok", 32'(wok), 32'h1);
      go(TMW_CMD_WRITE, TAG_UID, 8'h10, 8'h00, 32'h5A000000, 1'b1);
      rsp_is(1'b1, TMW_RSP_ERR, 1'b0);
      check("write_ok", 32'(wok), 32'h0);
      $display("test write_lock done");
   endtask

   task automatic t_quad();
      go(TMW_CMD_QUAD, TAG_UID, 8'h20, 8'hA0, 32'h11223344, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK, 1'b1);
      check("nv_addr", 32'(u_rdr.seen_addr), 32'h20);
      check("nv_be", 32'(u_rdr.seen_be), 32'hA);
      check("nv_data", u_rdr.seen_data, 32'h11223344);
      go(TMW_CMD_LOCK, TAG_UID, 8'h20, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK_NOK, 1'b0);
      go(TMW_CMD_QUERY, TAG_UID, 8'h24, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK_NOK, 1'b0);
      go(TMW_CMD_QUAD, TAG_UID, 8'h10, 8'h70, 32'h55667788, 1'b1);
      rsp_is(1'b1, TMW_RSP_ERR, 1'b0);
      $display("test quad done");
   endtask

   task automatic t_query();
      go(TMW_CMD_QUERY, TAG_UID, 8'h10, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ERR_NOK, 1'b0);
      go(TMW_CMD_WRITE, TAG_UID, 8'h30, 8'h00, 32'h3C000000, 1'b1);
      go(TMW_CMD_QUERY, TAG_UID, 8'h10, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ERR_OK, 1'b0);
      go(TMW_CMD_QUERY, TAG_UID, 8'h34, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK_OK, 1'b0);
      go(TMW_CMD_LOCK, TAG_UID, 8'h34, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b1, TMW_RSP_ACK, 1'b0);
      $display("test query done");
   endtask

   task automatic t_bcast();
      go(TMW_CMD_INIT, OTHER, 8'h00, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b0, TMW_RSP_ACK, 1'b0);
      check("xfer", 32'(xfer), 32'h0);
      go(TMW_CMD_BCAST, OTHER, 8'h40, 8'h00, 32'h77000000, 1'b1);
      rsp_is(1'b0, TMW_RSP_ACK, 1'b0);
      go(TMW_CMD_LOCK, TAG_UID, 8'h30, 8'h00, 32'h0, 1'b1);
      rsp_is(1'b0, TMW_RSP_ACK, 1'b0);
      @(posedge clk_sys_in);
      ident <= 1'b1;
      go(TMW_CMD_BCAST, OTHER, 8'h40, 8'h00, 32'h77000000, 1'b1);
      rsp_is(1'b0, TMW_RSP_ACK, 1'b1);
      check("nv_addr", 32'(u_rdr.seen_addr), 32'h40);
      check("write_ok", 32'(wok), 32'h1);
      go(TMW_CMD_BCAST, OTHER, 8'h10, 8'h00, 32'h77000000, 1'b1);
      rsp_is(1'b0, TMW_RSP_ACK, 1'b0);
      check("write_ok", 32'(wok), 32'h0);
      go(TMW_CMD_WRITE, TAG_UID, 8'h10, 8'h00, 32'h5A000000, 1'b1);
      check("xfer", 32'(xfer), 32'h1);
      $display("test broadcast done");
   endtask

   initial begin
      rst_in          = 1'b1;
      ident           = 1'b0;
      mismatches      = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      t_read();
      t_write();
      t_quad();
      t_query();
      t_bcast();
      results();
   end
endmodule
`default_nettype wire
